// >>> rtl/timer_pkg.sv
// Constants shared by the six-channel flexible timer unit.
package timer_pkg;
  // Function select codes held in the channel control register.
  typedef enum logic [1:0] {
    FN_AUTO_RELOAD,
    FN_COMPARE_OUT,
    FN_PULSE_WIDTH,
    FN_SNAPSHOT
  } func_t;
  localparam logic [1:0] FN_CODE_AUTO = 2'h0;
  localparam logic [1:0] FN_CODE_CMO = 2'h1;
  localparam logic [1:0] FN_CODE_PWM = 2'h2;
  localparam logic [1:0] FN_CODE_SNAP = 2'h3;
  // Pin action codes in the compare output function.
  localparam logic [1:0] ACT_CLEAR = 2'h0;
  localparam logic [1:0] ACT_SET = 2'h1;
  localparam logic [1:0] ACT_TOGGLE = 2'h2;
  // Edge select codes in the snapshot function.
  localparam logic [1:0] EDGE_NONE = 2'h0;
  localparam logic [1:0] EDGE_RISE = 2'h1;
  localparam logic [1:0] EDGE_FALL = 2'h2;
  localparam logic [1:0] EDGE_BOTH = 2'h3;
  // Count source select codes; 1 to 7 divide the system clock by 2**code, except 6 and 7 on channels 0 and 1, which pick the external pin.
  localparam logic [2:0] SRC_SYSCLK = 3'h0;
  localparam logic [2:0] SRC_EXT_RISE = 3'h6;
  localparam logic [2:0] SRC_EXT_FALL = 3'h7;
  // Number of channels that own an external count pin.
  localparam int EXT_CHANNELS = 2;
  // Register map: channel c sits at c * CH_STRIDE, word offsets inside.
  localparam logic [11:0] CH_STRIDE = 12'h020;
  localparam logic [2:0] IDX_CTRL = 3'h0;
  localparam logic [2:0] IDX_COUNT = 3'h1;
  localparam logic [2:0] IDX_COMPARE = 3'h2;
  localparam logic [2:0] IDX_RELOAD = 3'h3;
  localparam logic [2:0] IDX_PINCFG = 3'h4;
  localparam logic [2:0] IDX_OUTLVL = 3'h5;
  localparam logic [11:0] ADDR_START = 12'h0C0;
  localparam logic [11:0] ADDR_STOP = 12'h0C4;
  // Control register fields.
  localparam int CTRL_FN_LSB = 0;
  localparam int CTRL_SRC_LSB = 2;
  // Reset value and prescaler step.
  localparam logic [15:0] RST_WORD = 16'h0000;
  localparam logic [7:0] DIV_STEP = 8'h01;
endpackage

// >>> rtl/flex_timer.sv
// Six-channel flexible timer with compare output, pulse width and snapshot functions.
//
// Summary of operation
// - Function code 01 selects compare output; match acts on the output pin.
// - On match the pin goes low, high or toggles for codes 00, 01, 10.
// - Compare output raises overflow pulse on overflow and event pulse on match.
// - Function code 10 selects pulse width modulation on the output pin.
// - Period comes from the reload value, leading part from the compare value.
// - Code 00 outputs low while counter is at or below compare; 01 inverts.
// - Pulse width raises overflow pulse on overflow, no event pulse.
// - Function code 11 selects snapshot of the counter on input pin edges.
// - Each qualifying input edge copies the counter into the compare register.
// - Pin action picks the edge: none, rising, falling or both.
// - Snapshot raises overflow pulse on overflow and event pulse on capture.
// - One start write with several bits starts those channels together.
// - One stop write with several bits stops those channels together.
// - External count pin is sampled; counter steps two edges after a transition.
// - Source select picks rising or falling external transitions as count pulses.
// - In snapshot the shared pin is an undriven input.
// - Capture input is sampled; copy happens two edges after a transition.
// - Low-to-high is a rising trigger, high-to-low falling; both allows either.
// - In compare output and pulse width the shared pin is driven.
// - Compare output pin changes with the count pulse after the match.
// - Pulse width pin changes with the count pulse after the relation holds.
// - Software output level writes win and hold until the next timer update.
// - On overflow the counter reloads from the reload value.
//
// Local design decisions: the address map and the APB register port.
`timescale 1ns/10ps
`default_nettype none
module flex_timer
  import timer_pkg::*;
#(
  parameter int NCH = 6,
  parameter int CW = 16
) (
  // Clock and reset.
  input wire logic CLK,
  input wire logic RESETN,
  // APB slave port.
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [11:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  // Channel pins: shared input/output with active-low output enable.
  input wire logic [NCH-1:0] TIO_IN,
  output logic [NCH-1:0] TIO_OUT,
  output logic [NCH-1:0] TIO_OE_N,
  // External count pins for channels 0 and 1.
  input wire logic [EXT_CHANNELS-1:0] EXT_CLK,
  // One-cycle event pulses per channel.
  output logic [NCH-1:0] OVF_IRQ,
  output logic [NCH-1:0] EVT_IRQ
);

  // Refuse shapes the address decode and source select cannot serve.
  if (NCH < EXT_CHANNELS || NCH > 6 || CW < 2 || CW > 32) begin : g_bad_param
    $error("flex_timer: unsupported NCH or CW");
  end

  // The whole state of the block.
  typedef struct packed {
    logic [NCH-1:0][CW-1:0] cnt;
    logic [NCH-1:0][CW-1:0] cmp;
    logic [NCH-1:0][CW-1:0] rld;
    logic [NCH-1:0][1:0] fn;
    logic [NCH-1:0][1:0] act;
    logic [NCH-1:0][2:0] src;
    logic [NCH-1:0] en;
    logic [NCH-1:0] lvl;
    logic [NCH-1:0] oe_n;
    logic [NCH-1:0] ovf;
    logic [NCH-1:0] evt;
    logic [NCH-1:0] ext_pls;
    logic [NCH-1:0] ld_pls;
    logic [NCH-1:0] in_s1;
    logic [NCH-1:0] in_s2;
    logic [NCH-1:0] in_s3;
    logic [NCH-1:0] ck_s1;
    logic [NCH-1:0] ck_s2;
    logic [NCH-1:0] ck_s3;
    logic [7:0] div;
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
  } state_t;

  localparam logic [CW-1:0] CNT_MAX = {CW{1'b1}};

  state_t st_r;
  state_t st_nxt;
  logic [NCH-1:0] step;
  logic [NCH-1:0] match;
  logic wr_go;
  logic setup;
  logic [2:0] a_ch;
  logic [2:0] a_idx;
  logic ch_hit;

  // Next-state logic: bus slave, prescaler, synchronisers and channels.
  always_comb begin
    logic tick;
    logic rise;
    logic fall;
    logic [7:0] mask;
    tick = 1'b0;
    rise = 1'b0;
    fall = 1'b0;
    mask = 8'h00;
    st_nxt = st_r;
    st_nxt.div = st_r.div + DIV_STEP;
    setup = PSEL & ~PENABLE;
    wr_go = PSEL & PENABLE & st_r.pready & PWRITE;
    a_ch = PADDR[7:5];
    a_idx = PADDR[4:2];
    ch_hit = (PADDR[11:8] == 4'h0) && (int'(a_ch) < NCH) && (a_idx <= IDX_OUTLVL)
      && (PADDR[1:0] == 2'h0);
    // Every transfer is answered in its first access cycle.
    st_nxt.pready = setup;
    st_nxt.pslverr = 1'b0;
    st_nxt.prdata = 32'h0000_0000;
    if (setup) begin
      if (ch_hit) begin
        case (a_idx)
          IDX_CTRL: st_nxt.prdata = 32'({st_r.src[a_ch], st_r.fn[a_ch]});
          IDX_COUNT: st_nxt.prdata = 32'(st_r.cnt[a_ch]);
          IDX_COMPARE: st_nxt.prdata = 32'(st_r.cmp[a_ch]);
          IDX_RELOAD: st_nxt.prdata = 32'(st_r.rld[a_ch]);
          IDX_PINCFG: st_nxt.prdata = 32'(st_r.act[a_ch]);
          IDX_OUTLVL: st_nxt.prdata = 32'(st_r.lvl[a_ch]);
          default: st_nxt.prdata = 32'h0000_0000;
        endcase
      end else if (PADDR == ADDR_START) begin
        st_nxt.prdata = 32'(st_r.en);
      end else if (PADDR != ADDR_STOP) begin
        st_nxt.pslverr = 1'b1;
      end
    end
    // Two-stage synchronisers plus one history stage for edge detection.
    st_nxt.ck_s1 = NCH'(EXT_CLK);
    st_nxt.ck_s2 = st_r.ck_s1;
    st_nxt.ck_s3 = st_r.ck_s2;
    st_nxt.in_s1 = TIO_IN;
    st_nxt.in_s2 = st_r.in_s1;
    st_nxt.in_s3 = st_r.in_s2;
    for (int i = 0; i < NCH; i++) begin
      // Count pulse from the selected source.
      mask = 8'((9'h001 << st_r.src[i]) - 9'h001);
      if (st_r.src[i] == SRC_SYSCLK) begin
        tick = 1'b1;
      end else if (i < EXT_CHANNELS && st_r.src[i] >= SRC_EXT_RISE) begin
        tick = st_r.ext_pls[i];
      end else begin
        tick = (st_r.div & mask) == mask;
      end
      rise = st_r.ck_s2[i] & ~st_r.ck_s3[i];
      fall = ~st_r.ck_s2[i] & st_r.ck_s3[i];
      st_nxt.ext_pls[i] = (i < EXT_CHANNELS) &&
        ((st_r.src[i] == SRC_EXT_RISE && rise) || (st_r.src[i] == SRC_EXT_FALL && fall));
      step[i] = st_r.en[i] & tick;
      match[i] = step[i] && (st_r.cnt[i] == st_r.cmp[i]);
      st_nxt.ovf[i] = 1'b0;
      st_nxt.evt[i] = 1'b0;
      // Counter steps, and reloads past its all-ones value.
      if (step[i]) begin
        if (st_r.cnt[i] == CNT_MAX) begin
          st_nxt.cnt[i] = st_r.rld[i];
          st_nxt.ovf[i] = 1'b1;
        end else begin
          st_nxt.cnt[i] = st_r.cnt[i] + CW'(1);
        end
      end
      // Capture trigger edges from the synchronised input.
      rise = st_r.in_s2[i] & ~st_r.in_s3[i];
      fall = ~st_r.in_s2[i] & st_r.in_s3[i];
      st_nxt.ld_pls[i] = (st_r.fn[i] == FN_CODE_SNAP) &&
        (((st_r.act[i] == EDGE_RISE || st_r.act[i] == EDGE_BOTH) && rise) ||
         ((st_r.act[i] == EDGE_FALL || st_r.act[i] == EDGE_BOTH) && fall));
      // Software writes to channel registers.
      if (wr_go && ch_hit && int'(a_ch) == i) begin
        case (a_idx)
          IDX_CTRL: begin
            st_nxt.fn[i] = PWDATA[CTRL_FN_LSB +: 2];
            st_nxt.src[i] = PWDATA[CTRL_SRC_LSB +: 3];
          end
          IDX_COUNT: st_nxt.cnt[i] = PWDATA[CW-1:0];
          IDX_COMPARE: st_nxt.cmp[i] = PWDATA[CW-1:0];
          IDX_RELOAD: st_nxt.rld[i] = PWDATA[CW-1:0];
          IDX_PINCFG: st_nxt.act[i] = PWDATA[1:0];
          default: st_nxt.lvl[i] = st_r.lvl[i];
        endcase
      end
      // Function behaviour on pin and compare register.
      case (st_r.fn[i])
        FN_CODE_CMO: begin
          st_nxt.oe_n[i] = 1'b0;
          if (match[i]) begin
            st_nxt.evt[i] = 1'b1;
            case (st_r.act[i])
              ACT_CLEAR: st_nxt.lvl[i] = 1'b0;
              ACT_SET: st_nxt.lvl[i] = 1'b1;
              ACT_TOGGLE: st_nxt.lvl[i] = ~st_r.lvl[i];
              default: st_nxt.lvl[i] = st_r.lvl[i];
            endcase
          end
        end
        FN_CODE_PWM: begin
          st_nxt.oe_n[i] = 1'b0;
          if (step[i]) begin
            st_nxt.lvl[i] = (st_r.cnt[i] <= st_r.cmp[i]) ? st_r.act[i][0]
              : ~st_r.act[i][0];
          end
        end
        FN_CODE_SNAP: begin
          st_nxt.oe_n[i] = 1'b1;
          if (st_r.ld_pls[i]) begin
            st_nxt.cmp[i] = st_r.cnt[i];
            st_nxt.evt[i] = 1'b1;
          end
        end
        default: st_nxt.oe_n[i] = 1'b0;
      endcase
      // A software level write overrides the timer in the same cycle.
      if (wr_go && ch_hit && int'(a_ch) == i && a_idx == IDX_OUTLVL) begin
        st_nxt.lvl[i] = PWDATA[0];
      end
    end
    // Start and stop act on every selected channel in one cycle.
    if (wr_go && PADDR == ADDR_START) begin
      st_nxt.en = st_r.en | PWDATA[NCH-1:0];
    end
    if (wr_go && PADDR == ADDR_STOP) begin
      st_nxt.en = st_r.en & ~PWDATA[NCH-1:0];
    end
  end

  // State register; every field resets to a constant.
  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      st_r <= '0;
      st_r.oe_n <= '1;
    end else begin
      st_r <= st_nxt;
    end
  end

  // Outputs come straight from the state register.
  assign PRDATA = st_r.prdata;
  assign PREADY = st_r.pready;
  assign PSLVERR = st_r.pslverr;
  assign TIO_OUT = st_r.lvl;
  assign TIO_OE_N = st_r.oe_n;
  assign OVF_IRQ = st_r.ovf;
  assign EVT_IRQ = st_r.evt;

  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (!RESETN);

  // A start write sets exactly the written bits on top of the running set.
  a_start_group: assert property (
    wr_go && PADDR == ADDR_START |=> st_r.en == ($past(st_r.en) | $past(PWDATA[NCH-1:0])))
    else $error("start write did not start the selected channels together");

  // A stop write clears the written bits in the same cycle.
  a_stop_group: assert property (
    wr_go && PADDR == ADDR_STOP |=> (st_r.en & $past(PWDATA[NCH-1:0])) == '0)
    else $error("stop write left a selected channel running");

  // Sequence for a rising external transition on channel 0 with rising edges chosen.
  sequence s_ext_rise0;
    st_r.ck_s2[0] && !st_r.ck_s3[0] && st_r.src[0] == SRC_EXT_RISE && st_r.en[0];
  endsequence

  // The counter steps two edges after the detected transition.
  a_ext_count_delay: assert property (
    s_ext_rise0 ##0 !wr_go |-> !step[0] ##1 step[0])
    else $error("external count pulse not two edges after the transition");

  for (genvar c = 0; c < NCH; c++) begin : g_chk
    // Sequence for a count step that finds the counter at its top.
    sequence s_top_step;
      step[c] && st_r.cnt[c] == CNT_MAX && !wr_go;
    endsequence

    // Overflow reloads the counter and flags one pulse.
    a_ovf_reload: assert property (
      s_top_step |=> st_r.cnt[c] == $past(st_r.rld[c]) && OVF_IRQ[c])
      else $error("overflow did not reload from the reload value");

    // Compare output match drives the level chosen by the pin action.
    a_cmo_level: assert property (
      match[c] && st_r.fn[c] == FN_CODE_CMO && st_r.act[c] != 2'h3 && !wr_go
      |=> TIO_OUT[c] == ($past(st_r.act[c]) == ACT_TOGGLE ? !$past(TIO_OUT[c])
        : $past(st_r.act[c][0])) && EVT_IRQ[c])
      else $error("compare output level or event wrong after match");

    // Pulse width level follows the counter against the compare value.
    a_pwm_level: assert property (
      step[c] && st_r.fn[c] == FN_CODE_PWM && !wr_go
      |=> TIO_OUT[c] == (($past(st_r.cnt[c]) <= $past(st_r.cmp[c])) == $past(st_r.act[c][0]))
        && !EVT_IRQ[c])
      else $error("pulse width level wrong");

    // A load pulse copies the counter and raises the event.
    a_cap_copy: assert property (
      st_r.ld_pls[c] && st_r.fn[c] == FN_CODE_SNAP
      |=> st_r.cmp[c] == $past(st_r.cnt[c]) && EVT_IRQ[c])
      else $error("capture did not copy the counter");

    // A channel in snapshot leaves its pin undriven.
    a_pin_dir: assert property (
      st_r.fn[c] == FN_CODE_SNAP |=> TIO_OE_N[c] || $past(st_r.fn[c]) != FN_CODE_SNAP)
      else $error("snapshot channel is driving its pin");

    // Sequence for a rising trigger seen by a channel that captures on rising edges.
    sequence s_cap_rise;
      st_r.in_s2[c] && !st_r.in_s3[c] && st_r.fn[c] == FN_CODE_SNAP
        && st_r.act[c] == EDGE_RISE && !wr_go;
    endsequence

    // The load pulse follows the transition, and the copy with its event one edge later.
    a_cap_delay: assert property (
      s_cap_rise |=> st_r.ld_pls[c] ##1 EVT_IRQ[c])
      else $error("capture copy not two edges after the trigger");

    // A software level write wins over a timer update in the same cycle.
    a_lvl_write: assert property (
      wr_go && ch_hit && int'(a_ch) == c && a_idx == IDX_OUTLVL
      |=> TIO_OUT[c] == $past(PWDATA[0]))
      else $error("software level write lost against the timer");

    // A count step below the top advances the counter by exactly one.
    a_cnt_step: assert property (
      step[c] && st_r.cnt[c] != CNT_MAX && !wr_go
      |=> st_r.cnt[c] == $past(st_r.cnt[c]) + CW'(1))
      else $error("counter did not advance by one");
  end

endmodule
`default_nettype wire

// >>> testbench/pin_partner.sv
// Far-side pin model: drives the capture and external count pins and resolves shared pins.
`timescale 1ns/10ps
`default_nettype none
module pin_partner (
  // Clock.
  input wire logic clk,
  // Shared channel pins as seen from the board.
  input wire logic [5:0] tio_out,
  input wire logic [5:0] tio_oe_n,
  output logic [5:0] tio_in,
  // External count pins.
  output logic [1:0] ext_clk
);
  logic [5:0] cap_lvl;

  // A driven pin reads back the device level, an undriven one the level of this model.
  assign tio_in = (tio_oe_n & cap_lvl) | (~tio_oe_n & tio_out);

  // Both pin groups idle low from time zero.
  initial begin
    cap_lvl = 6'h00;
    ext_clk = 2'h0;
  end

  // One full pulse on a count pin; the high phase is held three cycles, the low phase two, above the minimum.
  task automatic ext_pulse(input int ch);
    @(posedge clk);
    ext_clk[ch] <= 1'b1;
    repeat (3) @(posedge clk);
    ext_clk[ch] <= 1'b0;
    repeat (2) @(posedge clk);
  endtask

  // One full pulse on a capture pin, with the same generous phase lengths.
  task automatic cap_pulse(input int ch);
    @(posedge clk);
    cap_lvl[ch] <= 1'b1;
    repeat (3) @(posedge clk);
    cap_lvl[ch] <= 1'b0;
    repeat (2) @(posedge clk);
  endtask
endmodule
`default_nettype wire

// >>> testbench/testbench.sv
// Self-checking bench for the flexible timer over its register bus and channel pins.
`timescale 1ns/10ps
`default_nettype none
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin errors++; $display("Error at %0t: got %h expected %h", $time, (g), (e)); end end
module testbench;
  import timer_pkg::*;
  logic CLK, RESETN, PSEL, PENABLE, PWRITE, PREADY, PSLVERR, er;
  logic [11:0] PADDR;
  logic [31:0] PWDATA, PRDATA, rd, r2;
  logic [5:0] TIO_IN, TIO_OUT, TIO_OE_N, OVF_IRQ, EVT_IRQ;
  logic [1:0] EXT_CLK;
  int errors, n_tests;
  int evt_n [6];
  int ovf_n [6];
  int exp_evt [4] = '{0, 1, 1, 2};
  logic [31:0] exp_cap [4] = '{32'hFFFF, 32'h4, 32'h7, 32'h7};

  flex_timer dut_u (.CLK(CLK), .RESETN(RESETN), .PSEL(PSEL), .PENABLE(PENABLE),
    .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY),
    .PSLVERR(PSLVERR), .TIO_IN(TIO_IN), .TIO_OUT(TIO_OUT), .TIO_OE_N(TIO_OE_N),
    .EXT_CLK(EXT_CLK), .OVF_IRQ(OVF_IRQ), .EVT_IRQ(EVT_IRQ));
  pin_partner partner_u (.clk(CLK), .tio_out(TIO_OUT), .tio_oe_n(TIO_OE_N), .tio_in(TIO_IN),
    .ext_clk(EXT_CLK));

  // Counts the one-cycle event and overflow pulses of every channel.
  always @(posedge CLK) begin
    for (int i = 0; i < 6; i++) begin
      if (EVT_IRQ[i] === 1'b1) evt_n[i]++;
      if (OVF_IRQ[i] === 1'b1) ovf_n[i]++;
    end
  end

  // One bus transfer; the request holds until ready is seen high at a rising edge.
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    @(posedge CLK);
    PSEL <= 1'b1;
    PENABLE <= 1'b0;
    PWRITE <= wr;
    PADDR <= a;
    PWDATA <= d;
    @(posedge CLK);
    PENABLE <= 1'b1;
    do @(posedge CLK); while (PREADY !== 1'b1);
    rd = PRDATA;
    er = PSLVERR;
    PSEL <= 1'b0;
    PENABLE <= 1'b0;
  endtask

  // Byte address of a channel register.
  function automatic logic [11:0] reg_addr(input int c, input logic [2:0] idx);
    return 12'(c) * CH_STRIDE + {7'h00, idx, 2'b00};
  endfunction

  // Control word from a function code and a count source.
  function automatic logic [31:0] ctrl(input logic [1:0] fn, input logic [2:0] src);
    return {27'h0, src, fn};
  endfunction

  task automatic wreg(input int c, input logic [2:0] idx, input logic [31:0] d);
    apb(1'b1, reg_addr(c, idx), d);
  endtask

  task automatic rreg(input int c, input logic [2:0] idx);
    apb(1'b0, reg_addr(c, idx), 32'h0);
  endtask

  // Programs function, pin action, counter and compare value of one channel.
  task automatic setup(input int c, input logic [31:0] cw, input logic [1:0] pin,
    input logic [15:0] cnt, input logic [15:0] cmp);
    wreg(c, IDX_CTRL, cw);
    wreg(c, IDX_PINCFG, {30'h0, pin});
    wreg(c, IDX_COUNT, {16'h0, cnt});
    wreg(c, IDX_COMPARE, {16'h0, cmp});
  endtask

  // Starts the masked channels, lets them run, then stops them in one write.
  task automatic run(input logic [31:0] mask, input int n);
    apb(1'b1, ADDR_START, mask);
    repeat (n) @(posedge CLK);
    apb(1'b1, ADDR_STOP, mask);
  endtask

  task automatic done(input string s);
    $display("Test %s finished", s);
  endtask

  task automatic end_sim;
    $display("Comparisons %0d, mismatches %0d", n_tests, errors);
    if (errors == 0 && n_tests > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  // Free-running 50 MHz system clock.
  initial begin
    CLK = 1'b0;
    forever #10 CLK = ~CLK;
  end

  // Cuts a hang short well after the tests should have ended.
  initial begin
    repeat (20000) @(posedge CLK);
    errors++;
    end_sim();
  end

  // Main sequence of tests.
  initial begin
    RESETN = 1'b0;
    PSEL = 1'b0;
    PENABLE = 1'b0;
    PWRITE = 1'b0;
    PADDR = 12'h000;
    PWDATA = 32'h0;
    errors = 0;
    n_tests = 0;
    repeat (16) @(posedge CLK);
    RESETN <= 1'b1;
    rreg(0, IDX_COUNT);
    `CHK(rd, 32'h0)
    `CHK(TIO_OE_N, 6'h00)
    apb(1'b0, 12'h0F0, 32'h0);
    `CHK(er, 1'b1)
    `CHK(rd, 32'h0)
    done("reset and map");
    for (int a = 0; a < 3; a++) begin
      setup(1, ctrl(FN_CODE_CMO, SRC_SYSCLK), 2'(a), 16'h0000, 16'h0004);
      wreg(1, IDX_OUTLVL, (a == 0) ? 32'h1 : 32'h0);
      evt_n[1] = 0;
      run(32'h02, 12);
      `CHK(TIO_OUT[1], (a == 0) ? 1'b0 : 1'b1)
      `CHK(TIO_OE_N[1], 1'b0)
      `CHK(evt_n[1], 1)
    end
    done("compare output");
    for (int a = 0; a < 2; a++) begin
      setup(2, ctrl(FN_CODE_PWM, SRC_SYSCLK), 2'(a), 16'h0000, 16'h8000);
      evt_n[2] = 0;
      run(32'h04, 5);
      `CHK(TIO_OUT[2], a[0])
      wreg(2, IDX_COUNT, 32'h9000);
      run(32'h04, 5);
      `CHK(TIO_OUT[2], ~a[0])
      `CHK(evt_n[2], 0)
    end
    done("pulse width");
    setup(2, ctrl(FN_CODE_AUTO, SRC_SYSCLK), 2'h0, 16'h0000, 16'h0000);
    setup(3, ctrl(FN_CODE_AUTO, SRC_SYSCLK), 2'h0, 16'h0000, 16'h0000);
    run(32'h0C, 7);
    rreg(2, IDX_COUNT);
    r2 = rd;
    rreg(3, IDX_COUNT);
    `CHK(rd, r2)
    done("joint start and stop");
    setup(4, ctrl(FN_CODE_AUTO, SRC_SYSCLK), 2'h0, 16'hFFFD, 16'h0000);
    wreg(4, IDX_RELOAD, 32'hFFF0);
    ovf_n[4] = 0;
    run(32'h10, 6);
    `CHK(ovf_n[4], 1)
    rreg(4, IDX_COUNT);
    `CHK(rd, 32'hFFF6)
    rreg(4, IDX_RELOAD);
    `CHK(rd, 32'hFFF0)
    done("overflow reload");
    setup(3, ctrl(FN_CODE_AUTO, 3'h3), 2'h0, 16'h0000, 16'h0000);
    run(32'h08, 13);
    rreg(3, IDX_COUNT);
    `CHK(rd, 32'h2)
    done("prescaled count");
    for (int s = 0; s < 2; s++) begin
      setup(0, ctrl(FN_CODE_AUTO, (s == 0) ? SRC_EXT_RISE : SRC_EXT_FALL), 2'h0, 16'h0, 16'h0);
      apb(1'b1, ADDR_START, 32'h01);
      repeat (3) partner_u.ext_pulse(0);
      repeat (4) @(posedge CLK);
      apb(1'b1, ADDR_STOP, 32'h01);
      rreg(0, IDX_COUNT);
      `CHK(rd, 32'h3)
    end
    done("external count");
    for (int e = 0; e < 4; e++) begin
      setup(5, ctrl(FN_CODE_SNAP, SRC_SYSCLK), 2'(e), 16'h0000, 16'hFFFF);
      apb(1'b1, ADDR_START, 32'h20);
      evt_n[5] = 0;
      partner_u.cap_pulse(5);
      repeat (4) @(posedge CLK);
      apb(1'b1, ADDR_STOP, 32'h20);
      `CHK(TIO_OE_N[5], 1'b1)
      `CHK(evt_n[5], exp_evt[e])
      rreg(5, IDX_COMPARE);
      `CHK(rd, exp_cap[e])
    end
    done("snapshot");
    end_sim();
  end
endmodule
`default_nettype wire
